// file: core/sep_eeprom_core.sv
// serial eeprom command decoder, protection, self-timed program cycle and read prefetch fifo
//
// How it works
// R01: written protect bits make protected bytes ignore writes even with latch set
// R02: protect bits stay rewritable by status write after latch set in soft protect
// R03: lock bit set and protect pin low together give hard protection
// R04: lock bit may be set alone later or together with protect bits
// R05: hard protection refuses status writes and protected byte writes
// R06: only protect pin high leaves hard protection, protect bits kept
// R07: read is opcode then 16 address bits, all sampled on rising clock
// R08: read data leaves on serial output, changing at falling clock
// R09: read address advances per byte and wraps to zero at the top
// R10: raising chip select stops a read at any point
// R11: read during program cycle is rejected, device acts deselected
// R12: host sends latch set in its own frame before each write
// R13: byte write is opcode, two address bytes, one data byte, select held
// R14: deselect right after a data byte starts programming, else write cancelled
// R15: busy flag high through the program cycle, latch cleared at its end
// R16: page write takes up to 64 bytes within one page
// R17: page offset wraps within the page and overwrites earlier bytes
// R18: power-up leaves device idle, latch cleared, stored status bits kept
// R19: nonvolatile write starts only when select rises on a byte boundary
// R20: array access during a program cycle is ignored, cycle continues
// R21: latch set and latch clear end in a wait until deselect; status read repeats the status byte until deselect
// R22: delivery state is all bytes FFh and status all zero
// R23: msb first, opcode first; an unknown opcode deselects
// R24: status holds lock bit 7, protect bits 3 and 2, latch 1, busy 0
`timescale 1ns/10ps
`include "sep_params.svh"

// flop fifo between array prefetch and serial output shifter
module sep_fifo #(
  parameter int WIDTH = 8,   // word width
  parameter int DEPTH = 16   // word count, power of two
) (
  input  wire logic             clk,        // system clock
  input  wire logic             rst,        // synchronous reset, high
  input  wire logic             flush,      // drop every word
  input  wire logic             in_valid,   // word offered
  output logic                  in_ready,   // room for a word
  input  wire logic [WIDTH-1:0] in_data,    // word in
  output logic                  out_valid,  // head word present
  input  wire logic             out_ready,  // head word taken
  output logic      [WIDTH-1:0] out_data    // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
  logic [DEPTH-1:0][WIDTH-1:0] mem_next;
  logic [AW:0]                 wp_reg;
  logic [AW:0]                 wp_next;
  logic [AW:0]                 rp_reg;
  logic [AW:0]                 rp_next;

  // extra pointer bit tells full from empty
  assign out_valid = wp_reg != rp_reg;
  assign in_ready  = (wp_reg[AW-1:0] != rp_reg[AW-1:0]) || (wp_reg[AW] == rp_reg[AW]);
  assign out_data  = mem_reg[rp_reg[AW-1:0]];

  // pointer and storage update
  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    if (flush) begin
      wp_next = '0;
      rp_next = '0;
    end else begin
      if (in_valid && in_ready) begin
        mem_next[wp_reg[AW-1:0]] = in_data;
        wp_next = wp_reg + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_next = rp_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg <= '0;
      wp_reg  <= '0;
      rp_reg  <= '0;
    end else begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
    end
  end
endmodule : sep_fifo

// device side of the serial eeprom
module sep_eeprom_core #(
  parameter int MEM_AW      = 8,                  // array address bits in use, above 6
  parameter int FIFO_DEPTH  = 16,                 // read prefetch depth
  parameter int PROG_CYCLES = `SEP_WRITE_CYCLES   // self-timed program cycle length
) (
  input  wire logic                  sys_clk,        // system clock, 125 MHz
  input  wire logic                  sys_rst,        // synchronous reset, high (power-on)
  input  wire sep_pkg::sep_pins_type pin_in,         // serial pins, asynchronous
  input  wire logic                  factory_init,   // pulse: load delivery state
  output logic                       spi_miso,       // serial data out
  output logic                       spi_miso_oe_n,  // low while spi_miso drives
  output logic [7:0]                 status_view     // live protection_status byte
);
  import sep_pkg::*;

  localparam int PAGE  = 1 << `SEP_PAGE_AW;
  localparam int DEPTH = 1 << MEM_AW;
  localparam int CW    = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  // protected block decode: none, upper quarter, upper half, all
  function automatic logic prot_hit(input logic [MEM_AW-1:0] a, input logic [1:0] bp);
    unique case (bp)
      2'b00: prot_hit = 1'b0;
      2'b01: prot_hit = &a[MEM_AW-1 -: 2];
      2'b10: prot_hit = a[MEM_AW-1];
      2'b11: prot_hit = 1'b1;
    endcase
  endfunction : prot_hit

  sep_pins_type s1_reg;
  sep_pins_type s2_reg;
  sep_pins_type s3_reg;

  // two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= `SEP_PINS_IDLE;
      s2_reg <= `SEP_PINS_IDLE;
      s3_reg <= `SEP_PINS_IDLE;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  sep_state_type                      st_reg,      st_next;
  logic [2:0]                         bits_reg,    bits_next;
  logic [7:0]                         sh_reg,      sh_next;
  logic                               rd_reg,      rd_next;
  logic                               abyte_reg,   abyte_next;
  logic [15:0]                        addr_reg,    addr_next;
  logic [`SEP_PAGE_AW-1:0]            pg_off_reg,  pg_off_next;
  logic [MEM_AW-1:`SEP_PAGE_AW]       pg_base_reg, pg_base_next;
  logic [PAGE-1:0][7:0]               pbuf_reg,    pbuf_next;
  logic [PAGE-1:0]                    pvalid_reg,  pvalid_next;
  logic                               got_reg,     got_next;
  logic [7:0]                         srnew_reg,   srnew_next;
  logic [MEM_AW-1:0]                  rdp_reg,     rdp_next;
  logic                               busy_reg,    busy_next;
  logic [CW-1:0]                      pcnt_reg,    pcnt_next;
  logic                               pkind_reg,   pkind_next;
  logic                               wel_reg,     wel_next;
  logic                               lock_reg,    lock_next;
  logic [1:0]                         bp_reg,      bp_next;
  logic [DEPTH-1:0][7:0]              mem_reg,     mem_next;
  logic [7:0]                         osh_reg,     osh_next;
  logic [2:0]                         obits_reg,   obits_next;
  logic                               miso_next;
  logic                               oe_n_next;
  logic                               set_wel;
  logic                               clr_wel;
  logic                               start_arr;
  logic                               start_sr;
  logic                               prog_done;
  logic                               fifo_pop;
  logic                               fifo_ready;
  logic                               fifo_valid;
  logic [7:0]                         fifo_data;
  logic [DEPTH-1:0]                   cell_we;

  wire       sck_rise  = s2_reg.sck & ~s3_reg.sck;
  wire       sck_fall  = ~s2_reg.sck & s3_reg.sck;
  wire       cs_rise   = s2_reg.cs_n & ~s3_reg.cs_n;
  wire       sel       = ~s2_reg.cs_n;
  wire       held      = ~s2_reg.hold_n;
  wire       hard_protect_state       = lock_reg & ~s2_reg.wp_n;                      // R03 R06
  wire [7:0] rx_byte   = {sh_reg[6:0], s2_reg.mosi};                  // R23
  wire       byte_done = sck_rise & sel & ~held & (bits_reg == 3'd7);
  wire       fifo_push = (st_reg == st_read) & fifo_ready;
  wire [7:0] out_byte  = (st_reg == st_read) ? fifo_data : status_view;

  // status byte: bits 6..4 read as zero
  assign status_view = {lock_reg, 3'b000, bp_reg, wel_reg, busy_reg};  // R24

  // frame decoder: bits sampled on synchronised rising clock edges
  always_comb begin
    st_next      = st_reg;
    bits_next    = bits_reg;
    sh_next      = sh_reg;
    rd_next      = rd_reg;
    abyte_next   = abyte_reg;
    addr_next    = addr_reg;
    pg_off_next  = pg_off_reg;
    pg_base_next = pg_base_reg;
    pbuf_next    = pbuf_reg;
    pvalid_next  = pvalid_reg;
    got_next     = got_reg;
    srnew_next   = srnew_reg;
    rdp_next     = fifo_push ? rdp_reg + 1'b1 : rdp_reg;               // R09
    set_wel      = 1'b0;
    clr_wel      = 1'b0;
    start_arr    = 1'b0;
    start_sr     = 1'b0;
    if (cs_rise) begin
      // only a deselect on a byte boundary commits; anything else is dropped
      start_arr = (st_reg == st_wdata) && got_reg && (bits_reg == 3'd0) && wel_reg; // R14 R19
      start_sr  = (st_reg == st_srfull) && (bits_reg == 3'd0) && wel_reg && !hard_protect_state;   // R02 R05
      st_next   = st_idle;                                                          // R10
    end else if (!sel) begin
      st_next   = st_idle;
      bits_next = 3'd0;
    end else if (st_reg == st_idle) begin
      st_next    = st_cmd;
      bits_next  = 3'd0;
      abyte_next = 1'b0;
    end else if (sck_rise && !held) begin
      bits_next = bits_reg + 3'd1;
      sh_next   = rx_byte;
      if (st_reg == st_srfull) begin
        st_next = st_wait;                      // clock past the status byte cancels it
      end else if (bits_reg == 3'd7) begin
        unique case (st_reg)
          st_cmd: begin
            rd_next = 1'b0;
            st_next = st_wait;                                                      // R21 R23
            if (rx_byte == `SEP_OP_LATCH_SET) begin
              set_wel = 1'b1;                                                       // R12
            end else if (rx_byte == `SEP_OP_LATCH_CLR) begin
              clr_wel = 1'b1;
            end else if (rx_byte == `SEP_OP_STATUS_RD) begin
              st_next = st_srread;                                                  // R15
            end else if (rx_byte == `SEP_OP_STATUS_WR && !busy_reg) begin
              st_next = st_srwr;
            end else if (rx_byte == `SEP_OP_READ && !busy_reg) begin
              st_next = st_addr;                                                    // R11
              rd_next = 1'b1;
            end else if (rx_byte == `SEP_OP_WRITE && !busy_reg) begin
              st_next     = st_addr;                                                // R20
              pvalid_next = '0;
              got_next    = 1'b0;
            end
          end
          st_addr: begin
            addr_next  = {addr_reg[7:0], rx_byte};                                  // R07
            abyte_next = ~abyte_reg;
            if (abyte_reg) begin
              st_next      = rd_reg ? st_read : st_wdata;
              rdp_next     = addr_next[MEM_AW-1:0];
              pg_off_next  = addr_next[`SEP_PAGE_AW-1:0];
              pg_base_next = addr_next[MEM_AW-1:`SEP_PAGE_AW];
            end
          end
          st_wdata: begin
            pbuf_next[pg_off_reg]   = rx_byte;                                      // R16
            pvalid_next[pg_off_reg] = 1'b1;
            pg_off_next             = pg_off_reg + 1'b1;                            // R17
            got_next                = 1'b1;
          end
          st_srwr: begin
            srnew_next = rx_byte;
            st_next    = st_srfull;
          end
          st_idle, st_srfull, st_srread, st_read, st_wait: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg      <= st_idle;                                                       // R18
      bits_reg    <= 3'd0;
      sh_reg      <= 8'h00;
      rd_reg      <= 1'b0;
      abyte_reg   <= 1'b0;
      addr_reg    <= 16'h0000;
      pg_off_reg  <= '0;
      pg_base_reg <= '0;
      pbuf_reg    <= '0;
      pvalid_reg  <= '0;
      got_reg     <= 1'b0;
      srnew_reg   <= `SEP_SR_RESET;
      rdp_reg     <= '0;
    end else begin
      st_reg      <= st_next;
      bits_reg    <= bits_next;
      sh_reg      <= sh_next;
      rd_reg      <= rd_next;
      abyte_reg   <= abyte_next;
      addr_reg    <= addr_next;
      pg_off_reg  <= pg_off_next;
      pg_base_reg <= pg_base_next;
      pbuf_reg    <= pbuf_next;
      pvalid_reg  <= pvalid_next;
      got_reg     <= got_next;
      srnew_reg   <= srnew_next;
      rdp_reg     <= rdp_next;
    end
  end

  // program cycle, write enable latch and nonvolatile status bits
  always_comb begin
    busy_next  = busy_reg;
    pcnt_next  = busy_reg ? pcnt_reg + 1'b1 : pcnt_reg;
    pkind_next = pkind_reg;
    wel_next   = wel_reg;
    lock_next  = lock_reg;
    bp_next    = bp_reg;
    prog_done  = busy_reg && (pcnt_reg == PROG_LAST);
    if (prog_done) begin
      busy_next = 1'b0;                                                             // R15
      wel_next  = 1'b0;
      if (pkind_reg) begin
        lock_next = srnew_reg[`SEP_SR_LOCK_BIT];                                    // R04
        bp_next   = {srnew_reg[`SEP_SR_BP_HI_BIT], srnew_reg[`SEP_SR_BP_LO_BIT]};   // R02
      end
    end
    if (start_arr || start_sr) begin
      busy_next  = 1'b1;
      pcnt_next  = '0;
      pkind_next = start_sr;
    end
    if (clr_wel) begin
      wel_next = 1'b0;
    end
    // a latch set arriving with the end of a cycle survives it
    if (set_wel) begin
      wel_next = 1'b1;
    end
    if (factory_init) begin
      lock_next = 1'b0;                                                             // R22
      bp_next   = 2'b00;
    end
  end

  // lock and protect bits model nonvolatile cells: untouched by reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_reg  <= 1'b0;
      pcnt_reg  <= '0;
      pkind_reg <= 1'b0;
      wel_reg   <= 1'b0;                                                            // R18
    end else begin
      busy_reg  <= busy_next;
      pcnt_reg  <= pcnt_next;
      pkind_reg <= pkind_next;
      wel_reg   <= wel_next;
    end
    lock_reg <= lock_next;
    bp_reg   <= bp_next;
  end

  // per-byte write strobe: in the page, loaded, and outside the protected block
  for (genvar g = 0; g < DEPTH; g++) begin : g_cell
    localparam logic [MEM_AW-1:0] IDX = MEM_AW'(g);
    assign cell_we[g] = prog_done && !pkind_reg && pvalid_reg[IDX[`SEP_PAGE_AW-1:0]]
                        && (IDX[MEM_AW-1:`SEP_PAGE_AW] == pg_base_reg)
                        && !prot_hit(IDX, bp_reg);                                  // R01 R05
  end

  // array commits only when the program cycle ends
  always_comb begin
    mem_next = mem_reg;
    for (int i = 0; i < DEPTH; i++) begin
      if (factory_init) begin
        mem_next[i] = `SEP_ERASED_BYTE;                                             // R22
      end else if (cell_we[i]) begin
        mem_next[i] = pbuf_reg[i % PAGE];
      end
    end
  end

  // array is nonvolatile: reset leaves it alone
  always_ff @(posedge sys_clk) begin
    mem_reg <= mem_next;
  end

  // prefetch keeps the shifter fed; flushed whenever the read frame ends
  sep_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_prefetch (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .flush     (st_reg != st_read),                                                 // R10
    .in_valid  (st_reg == st_read),
    .in_ready  (fifo_ready),
    .in_data   (mem_reg[rdp_reg]),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // output shifter: a new bit leaves on each synchronised falling clock edge
  always_comb begin
    osh_next   = osh_reg;
    obits_next = obits_reg;
    miso_next  = spi_miso;
    fifo_pop   = 1'b0;
    oe_n_next  = !((st_next == st_read || st_next == st_srread) && !held);
    if (st_reg != st_read && st_reg != st_srread) begin
      obits_next = 3'd0;
    end else if (sck_fall && !held) begin
      if (obits_reg == 3'd0) begin
        // status read reloads live bits every byte so busy can be polled
        fifo_pop   = (st_reg == st_read) && fifo_valid;
        miso_next  = out_byte[7];                                                   // R08
        osh_next   = {out_byte[6:0], 1'b0};
        obits_next = 3'd7;
      end else begin
        miso_next  = osh_reg[7];
        osh_next   = {osh_reg[6:0], 1'b0};
        obits_next = obits_reg - 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      osh_reg       <= 8'h00;
      obits_reg     <= 3'd0;
      spi_miso      <= 1'b1;
      spi_miso_oe_n <= 1'b1;
    end else begin
      osh_reg       <= osh_next;
      obits_reg     <= obits_next;
      spi_miso      <= miso_next;
      spi_miso_oe_n <= oe_n_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_READ_REJECT: assert property (                                                // R11
    byte_done && st_reg == st_cmd && rx_byte == `SEP_OP_READ && busy_reg
    |=> st_reg == st_wait && spi_miso_oe_n) else $error("read accepted while busy");
  AST_BUSY_HOLD: assert property (                                                  // R15
    busy_reg && pcnt_reg != PROG_LAST |=> busy_reg) else $error("busy dropped early");
  AST_WEL_CLEAR: assert property (                                                  // R15
    prog_done && !set_wel |=> !wel_reg && !busy_reg) else $error("latch kept after cycle");
  AST_SR_LOCKED: assert property (                                                  // R05
    cs_rise && st_reg == st_srfull && hard_protect_state |=> !busy_reg [*2]) else $error("status write in hpm");
  AST_PROT_ALL: assert property (                                                   // R01
    prog_done && !pkind_reg && bp_reg == 2'b11 && !factory_init
    |=> mem_reg == $past(mem_reg)) else $error("protected array changed");
  AST_MISALIGNED: assert property (                                                 // R14
    cs_rise && st_reg == st_wdata && bits_reg != 3'd0 |=> !busy_reg) else $error("odd deselect programmed");
  AST_MISO_FALL: assert property (                                                  // R08
    $changed(spi_miso) |-> $past(sck_fall)) else $error("output moved off falling edge");
  AST_BADOP: assert property (                                                      // R23
    byte_done && st_reg == st_cmd && !(rx_byte inside {`SEP_OP_LATCH_SET, `SEP_OP_LATCH_CLR,
      `SEP_OP_STATUS_RD, `SEP_OP_STATUS_WR, `SEP_OP_READ, `SEP_OP_WRITE})
    |=> st_reg == st_wait ##1 spi_miso_oe_n) else $error("unknown opcode not deselected");
  AST_RD_WRAP: assert property (                                                    // R09
    fifo_push && &rdp_reg |=> rdp_reg == '0) else $error("read address did not wrap");
  AST_SR_UPDATE: assert property (                                                  // R04
    prog_done && pkind_reg && !factory_init
    |=> bp_reg == srnew_reg[3:2] && lock_reg == srnew_reg[7]) // byte held while busy
    else $error("status bits not committed");
endmodule : sep_eeprom_core

// file: core/sep_params.svh
// opcodes, status bit layout, reset values and timing counts of the serial eeprom core
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// command opcodes, most significant bit first on the wire
`define SEP_OP_LATCH_SET  8'h06
`define SEP_OP_LATCH_CLR  8'h04
`define SEP_OP_STATUS_RD  8'h05
`define SEP_OP_STATUS_WR  8'h01
`define SEP_OP_READ       8'h03
`define SEP_OP_WRITE      8'h02

// protection_status bit positions
`define SEP_SR_LOCK_BIT   7
`define SEP_SR_BP_HI_BIT  3
`define SEP_SR_BP_LO_BIT  2
`define SEP_SR_WEL_BIT    1
`define SEP_SR_BUSY_BIT   0

// reset and delivery values
`define SEP_SR_RESET      8'h00
`define SEP_ERASED_BYTE   8'hFF
`define SEP_PINS_IDLE     5'h0F

// page geometry: 64 bytes
`define SEP_PAGE_AW       6

// self-timed program cycle
`define SEP_CLK_MHZ       125
`define SEP_WRITE_TIME_MS 10
`define SEP_WRITE_CYCLES  (`SEP_WRITE_TIME_MS * 1000 * `SEP_CLK_MHZ)

`endif

// file: core/sep_pkg.sv
// types shared by the serial eeprom core
package sep_pkg;

  // serial pins as they arrive from the board
  typedef struct packed {
    logic sck;     // serial clock
    logic cs_n;    // chip select, low active
    logic mosi;    // serial data in
    logic wp_n;    // write protect, low active
    logic hold_n;  // hold, low active
  } sep_pins_type;

  // frame decoder states
  typedef enum logic [3:0] {
    st_idle, st_cmd, st_addr, st_wdata, st_srwr, st_srfull, st_srread, st_read, st_wait
  } sep_state_type;

endpackage : sep_pkg

// file: tb/sep_host_model.sv
// serial bus master model driving the eeprom pins in spi mode 0
`timescale 1ns/10ps
`include "sep_params.svh"
module sep_host_model (
  input  wire logic             clk,   // bench clock, paces the serial clock
  input  wire logic             miso,  // resolved serial data line
  output sep_pkg::sep_pins_type pins   // pins toward the device
);
  import sep_pkg::*;
  // serial clock idles low, select high, between frames
  initial begin
    pins = `SEP_PINS_IDLE;
  end
  // half a serial period is five system clocks, 80 ns per bit
  task automatic half();
    repeat (5) @(posedge clk);
    #1;
  endtask : half
  // data set while the clock is low, both sides sample at the rise
  task automatic bit_x(input logic b, output logic r);
    pins.mosi = b;
    half();
    pins.sck = 1'b1;
    r = miso;
    half();
    pins.sck = 1'b0;
  endtask : bit_x
  // whole frame: bytes out msb first, n bytes in, then stray bits
  task automatic frame(input logic [7:0] tx[$], input int n, input int xb,
                       output logic [7:0] rx[$]);
    logic       r;
    logic [7:0] v;
    rx = {};
    pins.cs_n = 1'b0;
    half();
    foreach (tx[i]) for (int k = 7; k >= 0; k--) bit_x(tx[i][k], r);
    repeat (n) begin
      for (int k = 7; k >= 0; k--) begin
        bit_x(1'b0, r);
        v[k] = r;
      end
      rx.push_back(v);
    end
    repeat (xb) bit_x(1'b0, r);
    half();
    pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi; // released line must not look stable
    half();
  endtask : frame
endmodule : sep_host_model

// file: tb/spi_eeprom_access_protect_tb_top.sv
// self-checking bench for the serial eeprom core
`timescale 1ns/10ps
module spi_eeprom_access_protect_tb_top;
  import sep_pkg::*;
  localparam int PROG = 400;
  logic         sys_clk      = 1'b0;
  logic         sys_rst      = 1'b1;
  logic         factory_init = 1'b0;
  logic         spi_miso, spi_miso_oe_n, miso_line, drove;
  logic [7:0]   status_view, exp_sr, a;
  logic [7:0]   exp_mem [256];
  logic [7:0]   rx[$], d[$];
  sep_pins_type pins;
  int           error_cnt = 0;
  int           compares = 0;
  int           cycles = 0;
  always #4 sys_clk = ~sys_clk;
  // released data line is pulled up
  assign miso_line = spi_miso_oe_n ? 1'b1 : spi_miso;
  sep_host_model host (.clk(sys_clk), .miso(miso_line), .pins(pins));
  sep_eeprom_core #(.MEM_AW(8), .FIFO_DEPTH(16), .PROG_CYCLES(PROG)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pins), .factory_init(factory_init),
    .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .status_view(status_view));
  // drive watch and hang guard, well above the expected 24k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (spi_miso_oe_n === 1'b0) drove = 1'b1;
    if (cycles == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic prot(input logic [7:0] x, input logic [1:0] bp);
    return bp == 2'b11 || (bp == 2'b10 && x[7]) || (bp == 2'b01 && x[7:6] == 2'b11);
  endfunction : prot
  task automatic wait_idle();
    for (int i = 0; i < 600 && status_view[0] !== 1'b0; i++) @(posedge sys_clk);
    #1;
  endtask : wait_idle
  task automatic latch_set_cmd();
    host.frame({8'h06}, 0, 0, rx);
  endtask : latch_set_cmd
  // write n random bytes, en sets the latch first, xb stray bits after data
  task automatic wr(input logic [7:0] x, input int n, input logic en, input int xb);
    logic       go;
    logic [7:0] p;
    d = {};
    repeat (n) d.push_back(8'($urandom));
    if (en) latch_set_cmd();
    go = en && xb == 0 && !prot(x, exp_sr[3:2]);
    host.frame({8'h02, 8'h00, x, d}, 0, xb, rx);
    if (!go && prot(x, exp_sr[3:2]) && en && xb == 0) ; // protected: busy outcome left open
    else chk(8'(status_view[0]), 8'(go), "busy after write");
    if (go) begin
      drove = 1'b0;
      host.frame({8'h03, 8'h00, x}, 1, 0, rx);
      chk(8'(drove), 8'h00, "output during program cycle");
    end
    foreach (d[i]) begin
      p = {x[7:6], 6'(x[5:0] + i)};
      if (go) exp_mem[p] = d[i];
    end
    wait_idle();
    if (go) chk(status_view, exp_sr, "latch after cycle");
  endtask : wr
  task automatic rd(input logic [7:0] x, input int n);
    host.frame({8'h03, 8'h00, x}, n, 0, rx);
    foreach (rx[i]) chk(rx[i], exp_mem[8'(x + i)], "read data");
  endtask : rd
  task automatic sr_wr(input logic [7:0] v);
    latch_set_cmd();
    host.frame({8'h01, v}, 0, 0, rx);
    if (!(exp_sr[7] && !pins.wp_n)) exp_sr = v & 8'h8C;
    wait_idle();
    host.frame({8'h04}, 0, 0, rx);
    chk(status_view, exp_sr, "status after write");
  endtask : sr_wr
  // main sequence
  initial begin
    void'($urandom(96296));
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    exp_sr = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    factory_init = 1'b1;
    @(posedge sys_clk);
    #1 factory_init = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(status_view, 8'h00, "delivery status");
    rd(8'($urandom), 2);
    $display("test delivery done");
    latch_set_cmd();
    chk(status_view, 8'h02, "latch set");
    host.frame({8'h05}, 2, 0, rx);
    chk(rx[1], 8'h02, "status read");
    host.frame({8'h04}, 0, 0, rx);
    chk(status_view, 8'h00, "latch clear");
    // unknown opcode: output stays released, so the pull-up reads back
    host.frame({8'h5A}, 1, 0, rx);
    chk(rx[0], 8'hFF, "unknown opcode drove output");
    $display("test latch done");
    a = 8'($urandom);
    wr(a, 1, 1'b0, 0);
    wr(a, 1, 1'b1, 3);
    wr(8'hFF, 1, 1'b1, 0);
    wr(8'h00, 1, 1'b1, 0);
    rd(8'hFF, 2);
    rd(a, 1);
    wr(8'h7E, 66, 1'b1, 0);
    rd(8'h40, 64);
    $display("test write done");
    sr_wr(8'h04);
    wr(8'hC5, 1, 1'b1, 0);
    wr(8'h15, 1, 1'b1, 0);
    rd(8'hC5, 1);
    rd(8'h15, 1);
    sr_wr(8'h08);
    host.pins.wp_n = 1'b0;
    sr_wr(8'h8C);
    sr_wr(8'h00);
    wr(8'h05, 1, 1'b1, 0);
    rd(8'h05, 1);
    host.pins.wp_n = 1'b1;
    sr_wr(8'h84);
    host.pins.wp_n = 1'b0;
    sr_wr(8'h00);
    host.pins.wp_n = 1'b1;
    sr_wr(8'h00);
    $display("test protect done");
    print_verdict();
  end
endmodule : spi_eeprom_access_protect_tb_top
